// >>> tb/spsf_bus_model.sv
`timescale 1ns/10ps
`default_nettype none
module spsf_bus_model (
    output var logic scl,
    output var logic sda
);
    // Far-side bus master; both lines float high between frames
    initial begin
        scl = 1'b1;
        sda = 1'b1;
    end
    // Changes land on pclk edges, so they go non-blocking to avoid a sampling race
    task automatic start_cond();
        #40 sda <= 1'b0;
        #40 scl <= 1'b0;
    endtask : start_cond
    task automatic send_bit(input logic b);
        sda <= b;
        #40 scl <= 1'b1;
        #40 scl <= 1'b0;
    endtask : send_bit
    // Eight bits MSB first, then the ack slot; sda released afterwards
    task automatic send_byte(input logic [7:0] b, input logic nack);
        for (int i = 7; i >= 0; i--) begin
            send_bit(b[i]);
        end
        send_bit(nack);
        sda <= 1'b1;
    endtask : send_byte
    task automatic stop_cond();
        #20 sda <= 1'b0;
        #40 scl <= 1'b1;
        #40 sda <= 1'b1;
        #40;
    endtask : stop_cond
endmodule : spsf_bus_model
`default_nettype wire

// >>> tb/test_serial_port_status_flags.sv
`timescale 1ns/10ps
`default_nettype none
module test_serial_port_status_flags;
    import spsf_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, scl, sda;
    logic        slew_limit_off, smbus_levels, idle_clock_level, irq;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rdv;
    logic [1:0]  hi;
    logic [3:0]  c;
    logic [9:0]  a;
    logic        r, err;
    int          errors = 0;
    int          num_checks = 0;
    spsf_top u_spsf_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .scl_i(scl), .sda_i(sda), .slew_limit_off(slew_limit_off),
        .smbus_levels(smbus_levels), .idle_clock_level(idle_clock_level), .irq(irq));
    spsf_bus_model u_spsf_bus_model (.scl(scl), .sda(sda));
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end
    task automatic summarize();
        $display("checks %0d mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : summarize
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: %s got %h exp %h", $time, m, got, exp);
        end
    endtask : chk
    // Holds the request until pready is sampled high, or gives up with an error after 40 cycles
    task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= ad; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 40);
        if (n >= 40) begin
            errors++;
            $display("unexpected at %0t: no pready", $time);
        end
        rdv = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rd(input logic [7:0] ad, input logic [31:0] exp, input string m);
        apb(1'b0, ad, 32'h0);
        chk(rdv, exp, m);
    endtask : rd
    function automatic logic [31:0] stat(logic p, logic s, logic rw, logic u);
        return {24'h0, hi, 1'b0, p, s, rw, u, 1'b0};
    endfunction : stat
    task automatic waitc(input int n);
        repeat (n) @(posedge pclk);
    endtask : waitc
    initial begin
        #200000;
        errors++;
        summarize();
    end
    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        presetn = 1'b0;
        hi = 2'b00;
        void'($urandom(32'h6759));
        waitc(5);
        presetn <= 1'b1;
        rd(OFS_STATUS, 32'h0, "status reset");
        rd(OFS_CTRL, 32'h0, "ctrl reset");
        chk({29'h0, slew_limit_off, smbus_levels, irq}, 32'h0, "outputs at reset");
        $display("test reset done");
        for (int i = 0; i < 8; i++) begin
            c = 4'($urandom());
            hi = 2'($urandom());
            apb(1'b1, OFS_CTRL, {28'h0, c});
            apb(1'b1, OFS_STATUS, {24'h0, hi, 6'h3f});
            waitc(2);
            chk(slew_limit_off, c[CTL_TWO] & hi[1], "slew");
            chk(smbus_levels, c[CTL_TWO] & hi[0], "levels");
            chk(idle_clock_level, c[CTL_POL], "idle level");
            rd(OFS_STATUS, stat(0, 0, 0, 0), "status rw bits");
        end
        $display("test pad controls done");
        a = 10'($urandom());
        r = 1'($urandom());
        apb(1'b1, OFS_CTRL, 32'h5);
        apb(1'b1, OFS_ADDR, {25'h0, a[6:0]});
        apb(1'b1, OFS_IRQ_EN, 32'h7);
        u_spsf_bus_model.start_cond();
        rd(OFS_STATUS, stat(0, 1, 0, 0), "after start");
        u_spsf_bus_model.send_byte({a[6:0], r}, 1'b0);
        rd(OFS_STATUS, stat(0, 1, r, 0), "direction");
        rd(OFS_LINK, 32'h3, "window open");
        chk(irq, 1'b1, "irq raised");
        u_spsf_bus_model.stop_cond();
        rd(OFS_STATUS, stat(1, 0, r, 0), "after stop");
        rd(OFS_LINK, 32'h0, "window closed by stop");
        rd(OFS_IRQ_ST, 32'h7, "irq status");
        apb(1'b1, OFS_IRQ_EN, 32'h0);
        waitc(2);
        chk(irq, 1'b0, "irq masked");
        apb(1'b1, OFS_IRQ_EN, 32'h7);
        apb(1'b1, OFS_IRQ_CL, 32'h7);
        waitc(2);
        chk(irq, 1'b0, "irq cleared");
        rd(OFS_IRQ_ST, 32'h0, "irq status cleared");
        $display("test match and irq done");
        u_spsf_bus_model.start_cond();
        u_spsf_bus_model.send_byte({a[6:0], ~r}, 1'b1);
        rd(OFS_LINK, 32'h1, "window closed by not-ack");
        rd(OFS_STATUS, stat(0, 1, ~r, 0), "direction after not-ack");
        u_spsf_bus_model.stop_cond();
        $display("test not-ack done");
        apb(1'b1, OFS_CTRL, 32'hd);
        apb(1'b1, OFS_ADDR, {22'h0, a});
        u_spsf_bus_model.start_cond();
        u_spsf_bus_model.send_byte({TEN_PREFIX, a[9:8], 1'b0}, 1'b0);
        rd(OFS_STATUS, stat(0, 1, 0, 1), "update address set");
        apb(1'b1, OFS_ADDR, {22'h0, a});
        rd(OFS_STATUS, stat(0, 1, 0, 0), "update address cleared");
        rd(OFS_ADDR, {22'h0, a}, "address readback");
        u_spsf_bus_model.stop_cond();
        apb(1'b1, OFS_CTRL, 32'h0);
        rd(OFS_STATUS, stat(0, 0, 0, 0), "disable clears flags");
        $display("test ten-bit and disable done");
        apb(1'b0, 8'h1c, 32'h0);
        chk({31'h0, err}, 32'h1, "unmapped read error");
        chk(rdv, 32'h0, "unmapped read data");
        apb(1'b1, OFS_CTRL, 32'h5);
        u_spsf_bus_model.start_cond();
        u_spsf_bus_model.stop_cond();
        presetn <= 1'b0;
        waitc(2);
        presetn <= 1'b1;
        hi = 2'b00;
        rd(OFS_STATUS, stat(0, 0, 0, 0), "mid-run reset");
        $display("test unmapped and reset done");
        summarize();
    end
endmodule : test_serial_port_status_flags
`default_nettype wire

// >>> verilog/spsf_pkg.sv
`default_nettype none
package spsf_pkg;
    localparam logic [7:0] OFS_STATUS = 8'h00;
    localparam logic [7:0] OFS_CTRL   = 8'h04;
    localparam logic [7:0] OFS_ADDR   = 8'h08;
    localparam logic [7:0] OFS_IRQ_ST = 8'h0c;
    localparam logic [7:0] OFS_IRQ_CL = 8'h10;
    localparam logic [7:0] OFS_IRQ_EN = 8'h14;
    localparam logic [7:0] OFS_LINK   = 8'h18;
    localparam int BIT_SLEW  = 7;
    localparam int BIT_CKE   = 6;
    localparam int BIT_STOP  = 4;
    localparam int BIT_START = 3;
    localparam int BIT_RW    = 2;
    localparam int BIT_UPD   = 1;
    localparam int CTL_EN    = 0;
    localparam int CTL_POL   = 1;
    localparam int CTL_TWO   = 2;
    localparam int CTL_TEN   = 3;
    localparam int IRQ_START = 0;
    localparam int IRQ_STOP  = 1;
    localparam int IRQ_MATCH = 2;
    localparam logic [9:0] ADDR_RST   = 10'h000;
    localparam logic [3:0] CTRL_RST   = 4'h0;
    localparam logic [4:0] TEN_PREFIX = 5'h1e;
    localparam logic [3:0] BYTE_BITS  = 4'h8;
    typedef struct packed {
        logic sample_phase_slew_sel;
        logic cke;
        logic data_addr;
        logic stop;
        logic start;
        logic rw;
        logic update_address_flag;
        logic full;
    } spsf_status_t;
    typedef struct packed {
        logic ten_bit;
        logic two_wire;
        logic polarity;
        logic enable;
    } spsf_ctrl_t;
    typedef enum logic [1:0] {S_IDLE, S_ADDR, S_ACK, S_SKIP} spsf_state_t;
endpackage : spsf_pkg
`default_nettype wire

// >>> verilog/spsf_top.sv
// Added by the designer: the APB interface to the registers and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module spsf_top (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        scl_i,
    input  wire logic        sda_i,
    output logic             slew_limit_off,
    output logic             smbus_levels,
    output logic             idle_clock_level,
    output logic             irq
);
    import spsf_pkg::*;

    spsf_status_t st_q;
    spsf_ctrl_t   ctl_q;
    spsf_state_t  state_q;
    logic [9:0]   addr_q;
    logic [2:0]   irq_st_q, irq_en_q;
    logic         rw_valid_q, second_q;
    logic [3:0]   cnt_q;
    logic [7:0]   shift_q;
    logic [1:0]   scl_s, sda_s;
    logic         scl_p, sda_p;
    logic [31:0]  prdata_q;
    logic         pready_q, pslverr_q, irq_q;
    logic         slew_q, smb_q, idle_q;

    // Link pins are asynchronous; first stage feeds only the second
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            scl_s <= 2'h3;
            sda_s <= 2'h3;
            scl_p <= 1'b1;
            sda_p <= 1'b1;
        end else begin
            scl_s <= {scl_s[0], scl_i};
            sda_s <= {sda_s[0], sda_i};
            scl_p <= scl_s[1];
            sda_p <= sda_s[1];
        end
    end

    logic scl, sda, scl_rise, start_ev, stop_ev, en;
    assign scl      = scl_s[1];
    assign sda      = sda_s[1];
    assign scl_rise = scl & ~scl_p;
    assign en       = ctl_q.enable & ctl_q.two_wire;
    assign start_ev = en & scl & scl_p & sda_p & ~sda;
    assign stop_ev  = en & scl & scl_p & ~sda_p & sda;

    // APB decode
    logic acc, wr, rd_unmapped;
    assign acc = psel & penable & pready_q;
    assign wr  = acc & pwrite;
    assign rd_unmapped = !(paddr == OFS_STATUS || paddr == OFS_CTRL
        || paddr == OFS_ADDR || paddr == OFS_IRQ_ST || paddr == OFS_IRQ_CL
        || paddr == OFS_IRQ_EN || paddr == OFS_LINK);

    // Address byte decode at the eighth clock
    logic [7:0] byte_in;
    logic       last_bit, match_now, is_first_ten;
    assign byte_in   = {shift_q[6:0], sda};
    assign last_bit  = (state_q == S_ADDR) && scl_rise && (cnt_q == BYTE_BITS - 4'h1);
    assign is_first_ten = ctl_q.ten_bit && !second_q;
    always_comb begin
        if (!ctl_q.ten_bit)
            match_now = byte_in[7:1] == addr_q[6:0];
        else if (!second_q)
            match_now = byte_in[7:1] == {TEN_PREFIX, addr_q[9:8]};
        else
            match_now = byte_in == addr_q[7:0];
    end
    logic match_ev;
    assign match_ev = last_bit & match_now;

    // Receiver sequence
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q  <= S_IDLE;
            cnt_q    <= 4'h0;
            shift_q  <= 8'h00;
            second_q <= 1'b0;
        end else if (!en || start_ev || stop_ev) begin
            state_q  <= start_ev ? S_ADDR : S_IDLE;
            cnt_q    <= 4'h0;
            second_q <= 1'b0;
        end else begin
            case (state_q)
                S_ADDR: begin
                    if (scl_rise) begin
                        shift_q <= byte_in;
                        cnt_q   <= cnt_q + 4'h1;
                        if (last_bit)
                            state_q <= match_now ? S_ACK : S_SKIP;
                    end
                end
                S_ACK: begin
                    if (scl_rise) begin
                        cnt_q <= 4'h0;
                        if (is_first_ten && !shift_q[0]) begin
                            second_q <= 1'b1;
                            state_q  <= S_ADDR;
                        end else begin
                            state_q <= S_SKIP;
                        end
                    end
                end
                default: state_q <= state_q;
            endcase
        end
    end

    // Bus condition flags
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q.start <= 1'b0;
            st_q.stop  <= 1'b0;
        end else if (!ctl_q.enable) begin
            st_q.start <= 1'b0;
            st_q.stop  <= 1'b0;
        end else if (start_ev) begin
            st_q.start <= 1'b1;
            st_q.stop  <= 1'b0;
        end else if (stop_ev) begin
            st_q.stop  <= 1'b1;
            st_q.start <= 1'b0;
        end
    end

    // Direction and its validity window
    logic nack_ev;
    assign nack_ev = (state_q == S_ACK) && scl_rise && sda;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q.rw    <= 1'b0;
            rw_valid_q <= 1'b0;
        end else if (!ctl_q.enable) begin
            st_q.rw    <= 1'b0;
            rw_valid_q <= 1'b0;
        end else if (match_ev) begin
            st_q.rw    <= byte_in[0];
            rw_valid_q <= 1'b1;
        end else if (start_ev || stop_ev || nack_ev) begin
            rw_valid_q <= 1'b0;
        end
    end

    // Update-address request; a set in the same cycle as the reload wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            st_q.update_address_flag <= 1'b0;
        else if (!ctl_q.enable || !ctl_q.ten_bit)
            st_q.update_address_flag <= 1'b0;
        else if (match_ev)
            st_q.update_address_flag <= 1'b1;
        else if (wr && paddr == OFS_ADDR)
            st_q.update_address_flag <= 1'b0;
    end

    // Unimplemented status bits read as zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q.data_addr <= 1'b0;
            st_q.full      <= 1'b0;
        end else begin
            st_q.data_addr <= 1'b0;
            st_q.full      <= 1'b0;
        end
    end

    // Software-written configuration
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q.sample_phase_slew_sel <= 1'b0;
            st_q.cke                   <= 1'b0;
            ctl_q    <= CTRL_RST;
            addr_q   <= ADDR_RST;
            irq_en_q <= 3'h0;
        end else if (wr) begin
            if (paddr == OFS_STATUS) begin
                st_q.sample_phase_slew_sel <= pwdata[BIT_SLEW];
                st_q.cke                   <= pwdata[BIT_CKE];
            end else if (paddr == OFS_CTRL) begin
                ctl_q <= pwdata[3:0];
            end else if (paddr == OFS_ADDR) begin
                addr_q <= pwdata[9:0];
            end else if (paddr == OFS_IRQ_EN) begin
                irq_en_q <= pwdata[2:0];
            end
        end
    end

    // Sticky events; hardware set beats a clear in the same cycle
    logic [2:0] ev;
    assign ev = {match_ev, stop_ev, start_ev};
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            irq_st_q <= 3'h0;
        else if (wr && paddr == OFS_IRQ_CL)
            irq_st_q <= (irq_st_q & ~pwdata[2:0]) | ev;
        else
            irq_st_q <= irq_st_q | ev;
    end

    // Registered outputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_q  <= 1'b0;
            slew_q <= 1'b0;
            smb_q  <= 1'b0;
            idle_q <= 1'b0;
        end else begin
            irq_q  <= |(irq_st_q & irq_en_q);
            slew_q <= ctl_q.two_wire & st_q.sample_phase_slew_sel;
            smb_q  <= ctl_q.two_wire & st_q.cke;
            idle_q <= ctl_q.polarity;
        end
    end

    // One wait state, then the answer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0000_0000;
        end else begin
            pready_q  <= psel & penable & ~pready_q;
            pslverr_q <= psel & penable & ~pready_q & rd_unmapped;
            prdata_q  <= 32'h0000_0000;
            if (psel && penable && !pready_q && !pwrite) begin
                if (paddr == OFS_STATUS)
                    prdata_q <= {24'h000000, st_q};
                else if (paddr == OFS_CTRL)
                    prdata_q <= {28'h0000000, ctl_q};
                else if (paddr == OFS_ADDR)
                    prdata_q <= {22'h000000, addr_q};
                else if (paddr == OFS_IRQ_ST)
                    prdata_q <= {29'h00000000, irq_st_q};
                else if (paddr == OFS_IRQ_EN)
                    prdata_q <= {29'h00000000, irq_en_q};
                else if (paddr == OFS_LINK)
                    prdata_q <= {30'h00000000, rw_valid_q, state_q != S_IDLE};
            end
        end
    end

    assign prdata           = prdata_q;
    assign pready           = pready_q;
    assign pslverr          = pslverr_q;
    assign irq              = irq_q;
    assign slew_limit_off   = slew_q;
    assign smbus_levels     = smb_q;
    assign idle_clock_level = idle_q;

    a_stop_clears_start: assert property (@(posedge pclk) disable iff (!presetn)
        stop_ev && ctl_q.enable |=> !st_q.start && st_q.stop)
        else $error("start flag survived a stop");
    a_start_sets_flag: assert property (@(posedge pclk) disable iff (!presetn)
        start_ev && ctl_q.enable |=> st_q.start && !st_q.stop)
        else $error("start flag not set");
    a_disable_clears_stop: assert property (@(posedge pclk) disable iff (!presetn)
        !ctl_q.enable |=> !st_q.stop)
        else $error("stop flag kept while disabled");
    a_disable_clears_flags: assert property (@(posedge pclk) disable iff (!presetn)
        $fell(ctl_q.enable) |-> ##1 !st_q.start && !st_q.stop)
        else $error("flags kept after disable");
    a_dir_from_match: assert property (@(posedge pclk) disable iff (!presetn)
        match_ev && ctl_q.enable |=> st_q.rw == $past(sda) && rw_valid_q)
        else $error("direction not taken from address");
    a_dir_window_ends: assert property (@(posedge pclk) disable iff (!presetn)
        (start_ev || stop_ev || nack_ev) && !match_ev |=> !rw_valid_q)
        else $error("direction still valid");
    a_ua_only_ten: assert property (@(posedge pclk) disable iff (!presetn)
        !ctl_q.ten_bit |=> !st_q.update_address_flag)
        else $error("update flag outside ten-bit mode");
    a_slew_follows: assert property (@(posedge pclk) disable iff (!presetn)
        ##1 slew_limit_off == $past(ctl_q.two_wire && st_q.sample_phase_slew_sel))
        else $error("slew control mismatch");
    a_smbus_follows: assert property (@(posedge pclk) disable iff (!presetn)
        ##1 smbus_levels == $past(ctl_q.two_wire && st_q.cke))
        else $error("threshold select mismatch");
    a_idle_follows: assert property (@(posedge pclk) disable iff (!presetn)
        ##1 idle_clock_level == $past(ctl_q.polarity))
        else $error("idle level mismatch");
    a_upd_set_match: assert property (@(posedge pclk) disable iff (!presetn)
        match_ev && ctl_q.enable && ctl_q.ten_bit |=> st_q.update_address_flag)
        else $error("update flag not set on match");
    a_flags_exclusive: assert property (@(posedge pclk) disable iff (!presetn)
        !(st_q.start && st_q.stop))
        else $error("start and stop flags both set");
endmodule : spsf_top
`default_nettype wire
